// >>> src/flash_pin_pkg.sv
// Constants and types shared by the serial flash pin front end
package flash_pin_pkg;

  // Register byte offsets on the APB side
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] STATUS_OFFSET   = 8'h04;
  localparam logic [7:0] TX_DATA_OFFSET  = 8'h08;
  localparam logic [7:0] RX_DATA_OFFSET  = 8'h0c;
  localparam logic [7:0] STATE_OFFSET    = 8'h10;

  // Control register fields
  localparam int CTRL_RESTART_DIS_BIT = 0;
  localparam int CTRL_PIN_FUNC_BIT    = 1;
  localparam int CTRL_LANE_LSB        = 2;
  localparam int CTRL_DRIVE_BIT       = 4;
  localparam logic [4:0] CTRL_RESET   = 5'h00;

  // Status bit fields
  localparam int STAT_PROT_LSB        = 2;
  localparam int STAT_FOUR_LANE_BIT   = 6;
  localparam int STAT_LOCK_BIT        = 7;
  localparam logic [7:0] STAT_RESET   = 8'h00;

  // State register fields
  localparam int ST_SELECTED_BIT = 0;
  localparam int ST_STANDBY_BIT  = 1;
  localparam int ST_PAUSED_BIT   = 2;
  localparam int ST_RESTART_BIT  = 3;
  localparam int ST_ARMED_BIT    = 4;
  localparam int ST_RX_VALID_BIT = 5;
  localparam int ST_GUARD_BIT    = 6;
  localparam int ST_COUNT_LSB    = 8;

  localparam logic [7:0] TX_RESET = 8'hff;

  // Synchroniser reset levels: every pin idles high except the serial clock
  localparam logic [6:0] PIN_SYNC_RESET = 7'h6f;

  // Lane width selections
  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL   = 2'h1,
    LANE_QUAD   = 2'h2
  } lane_mode_type;

  // Pin levels after synchronisation
  typedef struct packed {
    logic       restart_n;
    logic       select_n;
    logic       sck;
    logic [3:0] lanes;
  } pin_in_type;

endpackage

// >>> src/serial_flash_pin_interface.sv
// Serial flash pin front end with APB register access
//
// Overview of operation
// - Select high: deselected, all outputs high impedance, standby asserted.
// - Select low: device selected, leaves standby, shifter accepts data.
// - Nothing accepted until select has fallen once after reset.
// - Input lanes ignored while select is high.
// - Single lane: serial_in sampled on rising serial clock edge.
// - Single lane: serial_out changes on falling serial clock edge.
// - Dual and quad lanes: sample on rising, drive from falling edges.
// - Quad mode uses write guard pin as lane 2, pause pin as lane 3.
// - Lock set and guard low blocks writes to lock, four-lane and range bits.
// - Lock clear leaves status bits writable at any guard level.
// - Four-lane enable disables the write guard function.
// - Four-lane enable disables pause and restart on the fourth pin.
// - Without dedicated restart, fourth pin is pause or restart by select bit.
// - Dedicated restart enabled: fourth pin pauses unless four-lane is enabled.
// - Dedicated restart disabled: fourth pin follows the function select bit.
// - Pause freezes shifting without losing state; resumes when released.
// - Pause while selected keeps serial_out high impedance.
// - Restart low holds restart state with outputs high impedance.
// - Control bit 0 enables or disables the dedicated restart pin.
// - Clock modes 0 and 3 both accepted, inputs on rising edges.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module serial_flash_pin_interface #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        device_select_n,
  input  wire logic        serial_clock,
  input  wire logic        hw_restart_n,
  input  wire logic [3:0]  data_lane_in,
  output logic      [3:0]  data_lane_out,
  output logic      [3:0]  data_lane_oe_n,
  output logic             standby
);

  logic [6:0]                      raw_pins;
  logic [6:0]                      sync_stage1_reg;
  logic [6:0]                      sync_stage2_reg;
  flash_pin_pkg::pin_in_type       pins;
  logic                            sck_prev_reg;
  logic                            select_prev_reg;
  logic                            armed_reg;
  logic [4:0]                      ctrl_reg;
  logic [7:0]                      status_reg;
  logic [7:0]                      tx_data_reg;
  logic [7:0]                      rx_data_reg;
  logic                            rx_valid_reg;
  logic [7:0]                      rx_shift_reg;
  logic [7:0]                      rx_shift_next;
  logic [7:0]                      tx_shift_reg;
  logic [2:0]                      bit_count_reg;
  logic [2:0]                      bit_count_next;
  logic                            rise_seen_reg;
  logic [31:0]                     prdata_reg;
  logic                            pslverr_reg;
  logic [3:0]                      lane_out_reg;
  logic [3:0]                      lane_oe_n_reg;
  logic                            standby_reg;
  flash_pin_pkg::lane_mode_type    lane_mode;
  logic [2:0]                      lane_width;
  logic                            four_lane;
  logic                            selected;
  logic                            restart_pin_en;
  logic                            fourth_is_pause;
  logic                            fourth_is_restart;
  logic                            paused;
  logic                            in_restart;
  logic                            guard_active;
  logic                            active;
  logic                            sck_rise;
  logic                            sck_fall;
  logic                            select_fall;
  logic                            apb_write;
  logic                            apb_read;
  logic                            addr_hit;
  logic                            byte_done;

  assign raw_pins = {hw_restart_n, device_select_n, serial_clock, data_lane_in};

  // Two flip-flop synchroniser per pin; only the second stage is read
  // Reset to each pin's idle level so no false clock edge follows reset
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_stage1_reg[gi] <= flash_pin_pkg::PIN_SYNC_RESET[gi];
          sync_stage2_reg[gi] <= flash_pin_pkg::PIN_SYNC_RESET[gi];
        end else begin
          sync_stage1_reg[gi] <= raw_pins[gi];
          sync_stage2_reg[gi] <= sync_stage1_reg[gi];
        end
      end
    end
  endgenerate

  assign pins = flash_pin_pkg::pin_in_type'(sync_stage2_reg);

  // Serial clock and select edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_reg    <= 1'b0;
      select_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg    <= pins.sck;
      select_prev_reg <= pins.select_n;
    end
  end

  // Either clock idle level works since only edges are used
  assign sck_rise    = pins.sck & ~sck_prev_reg;
  assign sck_fall    = ~pins.sck & sck_prev_reg;
  assign select_fall = select_prev_reg & ~pins.select_n;

  // Pin function decode for the fourth pin and write guard
  assign four_lane         = status_reg[flash_pin_pkg::STAT_FOUR_LANE_BIT];
  assign restart_pin_en    = ~ctrl_reg[flash_pin_pkg::CTRL_RESTART_DIS_BIT];
  assign fourth_is_restart = ~four_lane & ~restart_pin_en
                             & ctrl_reg[flash_pin_pkg::CTRL_PIN_FUNC_BIT];
  assign fourth_is_pause   = ~four_lane & ~fourth_is_restart;
  assign selected          = ~pins.select_n;
  assign in_restart        = (restart_pin_en & ~pins.restart_n)
                             | (fourth_is_restart & ~pins.lanes[3]);
  assign paused            = fourth_is_pause & ~pins.lanes[3] & selected;
  assign guard_active      = status_reg[flash_pin_pkg::STAT_LOCK_BIT]
                             & ~four_lane & ~pins.lanes[2];
  assign active            = selected & armed_reg & ~paused & ~in_restart;

  // Lane width; quad only with four-lane enabled
  always_comb begin
    lane_mode = flash_pin_pkg::lane_mode_type'(ctrl_reg[flash_pin_pkg::CTRL_LANE_LSB +: 2]);
    case (lane_mode)
      flash_pin_pkg::LANE_DUAL: lane_width = 3'h2;
      flash_pin_pkg::LANE_QUAD: lane_width = four_lane ? 3'h4 : 3'h1;
      default:                  lane_width = 3'h1;
    endcase
  end

  // Input shifter step for one rising edge
  always_comb begin
    case (lane_width)
      3'h2:    rx_shift_next = {rx_shift_reg[5:0], pins.lanes[1:0]};
      3'h4:    rx_shift_next = {rx_shift_reg[3:0], pins.lanes};
      default: rx_shift_next = {rx_shift_reg[6:0], pins.lanes[0]};
    endcase
    bit_count_next = bit_count_reg + lane_width;
  end

  assign byte_done = active & sck_rise & (bit_count_next == 3'h0);

  // First select fall after reset arms the shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (select_fall) begin
      armed_reg <= 1'b1;
    end
  end

  // Receive shifter and bit counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift_reg  <= 8'h00;
      bit_count_reg <= 3'h0;
      rise_seen_reg <= 1'b0;
    end else if (!selected || in_restart) begin
      rx_shift_reg  <= 8'h00;
      bit_count_reg <= 3'h0;
      rise_seen_reg <= 1'b0;
    end else if (active && sck_rise) begin
      rx_shift_reg  <= rx_shift_next;
      bit_count_reg <= bit_count_next;
      rise_seen_reg <= 1'b1;
    end
  end

  // Completed byte capture and flag; new byte wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_reg  <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else if (byte_done) begin
      rx_data_reg  <= rx_shift_next;
      rx_valid_reg <= 1'b1;
    end else if (apb_write && paddr == flash_pin_pkg::STATE_OFFSET
                 && pwdata[flash_pin_pkg::ST_RX_VALID_BIT]) begin
      rx_valid_reg <= 1'b0;
    end
  end

  // Transmit shifter moves only on falling edges after a rising one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_reg <= flash_pin_pkg::TX_RESET;
    end else if (select_fall) begin
      tx_shift_reg <= tx_data_reg;
    end else if (active && sck_fall && rise_seen_reg) begin
      if (bit_count_reg == 3'h0) begin
        tx_shift_reg <= tx_data_reg;
      end else begin
        tx_shift_reg <= tx_shift_reg << lane_width;
      end
    end
  end

  // Pin drivers; enable low means driving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_out_reg  <= 4'h0;
      lane_oe_n_reg <= 4'hf;
      standby_reg   <= 1'b1;
    end else begin
      standby_reg   <= pins.select_n;
      lane_out_reg  <= 4'h0;
      lane_oe_n_reg <= 4'hf;
      if (active) begin
        case (lane_width)
          3'h2: begin
            lane_out_reg[1:0] <= tx_shift_reg[7:6];
            lane_oe_n_reg     <= ctrl_reg[flash_pin_pkg::CTRL_DRIVE_BIT] ? 4'hc : 4'hf;
          end
          3'h4: begin
            lane_out_reg  <= tx_shift_reg[7:4];
            lane_oe_n_reg <= ctrl_reg[flash_pin_pkg::CTRL_DRIVE_BIT] ? 4'h0 : 4'hf;
          end
          default: begin
            lane_out_reg[1]  <= tx_shift_reg[7];
            lane_oe_n_reg[1] <= 1'b0;
          end
        endcase
      end
    end
  end

  assign data_lane_out  = lane_out_reg;
  assign data_lane_oe_n = lane_oe_n_reg;
  assign standby        = standby_reg;

  // APB decode; every access completes with no wait state
  assign apb_write = psel & penable & pwrite;
  assign apb_read  = psel & penable & ~pwrite;
  always_comb begin
    case (paddr)
      flash_pin_pkg::CTRL_OFFSET,
      flash_pin_pkg::STATUS_OFFSET,
      flash_pin_pkg::TX_DATA_OFFSET,
      flash_pin_pkg::RX_DATA_OFFSET,
      flash_pin_pkg::STATE_OFFSET: addr_hit = 1'b1;
      default:                     addr_hit = 1'b0;
    endcase
  end

  // Control and transmit data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= flash_pin_pkg::CTRL_RESET;
      tx_data_reg <= flash_pin_pkg::TX_RESET;
    end else if (apb_write) begin
      if (paddr == flash_pin_pkg::CTRL_OFFSET) begin
        ctrl_reg <= pwdata[4:0];
      end
      if (paddr == flash_pin_pkg::TX_DATA_OFFSET) begin
        tx_data_reg <= pwdata[7:0];
      end
    end
  end

  // Status bits, write blocked while the guard is active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= flash_pin_pkg::STAT_RESET;
    end else if (apb_write && paddr == flash_pin_pkg::STATUS_OFFSET && !guard_active) begin
      status_reg <= {pwdata[7:2], 2'b00};
    end
  end

  // Read data and error answer, registered in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      if (psel && !penable) begin
        pslverr_reg <= ~addr_hit;
        case (paddr)
          flash_pin_pkg::CTRL_OFFSET:    prdata_reg[4:0] <= ctrl_reg;
          flash_pin_pkg::STATUS_OFFSET:  prdata_reg[7:0] <= status_reg;
          flash_pin_pkg::TX_DATA_OFFSET: prdata_reg[7:0] <= tx_data_reg;
          flash_pin_pkg::RX_DATA_OFFSET: prdata_reg[7:0] <= rx_data_reg;
          flash_pin_pkg::STATE_OFFSET: begin
            prdata_reg[flash_pin_pkg::ST_SELECTED_BIT] <= selected;
            prdata_reg[flash_pin_pkg::ST_STANDBY_BIT]  <= standby_reg;
            prdata_reg[flash_pin_pkg::ST_PAUSED_BIT]   <= paused;
            prdata_reg[flash_pin_pkg::ST_RESTART_BIT]  <= in_restart;
            prdata_reg[flash_pin_pkg::ST_ARMED_BIT]    <= armed_reg;
            prdata_reg[flash_pin_pkg::ST_RX_VALID_BIT] <= rx_valid_reg;
            prdata_reg[flash_pin_pkg::ST_GUARD_BIT]    <= guard_active;
            prdata_reg[flash_pin_pkg::ST_COUNT_LSB +: 3] <= bit_count_reg;
          end
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata  = apb_read ? prdata_reg : 32'h0000_0000;
  assign pslverr = psel & penable & pslverr_reg;
  assign pready  = 1'b1;

endmodule // serial_flash_pin_interface

// >>> verif/serial_flash_pin_properties.sv
// Port checker for the serial flash pin front end
`timescale 1ns/1ns
module serial_flash_pin_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        device_select_n,
  input wire logic        hw_restart_n,
  input wire logic [3:0]  data_lane_in,
  input wire logic [3:0]  data_lane_oe_n,
  input wire logic        standby
);
  logic [4:0] ctrl_reg;
  logic       acc;
  logic       mapped;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Access phase and address decode
  assign acc = psel && penable;
  assign mapped = paddr inside {flash_pin_pkg::CTRL_OFFSET, flash_pin_pkg::STATUS_OFFSET,
    flash_pin_pkg::TX_DATA_OFFSET, flash_pin_pkg::RX_DATA_OFFSET, flash_pin_pkg::STATE_OFFSET};
  // Shadow of the control register taken from completed bus writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 5'h00;
    end else if (acc && pwrite && pready && paddr == flash_pin_pkg::CTRL_OFFSET) begin
      ctrl_reg <= pwdata[4:0];
    end
  end
  chk_desel_hiz: assert property (device_select_n [*5] |-> data_lane_oe_n == 4'hf)
    else $error("lanes driven while deselected");
  chk_standby_on: assert property (device_select_n [*5] |-> standby)
    else $error("standby low while deselected");
  chk_standby_off: assert property (!device_select_n [*5] |-> !standby)
    else $error("standby high while selected");
  chk_pause_hiz: assert property ((!device_select_n && !data_lane_in[3] && data_lane_oe_n[3]) [*5]
    |-> data_lane_oe_n[1]) else $error("serial out driven while paused");
  chk_restart_hiz: assert property ((!hw_restart_n && !ctrl_reg[0]) [*5] |-> data_lane_oe_n == 4'hf)
    else $error("lanes driven in restart");
  chk_no_wait: assert property (acc |-> pready)
    else $error("access phase stalled");
  chk_bad_addr: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without error");
  chk_good_addr: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access with error");
  chk_idle_data: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
  chk_ctrl_back: assert property (acc && !pwrite && paddr == flash_pin_pkg::CTRL_OFFSET
    |-> prdata == {27'h0, ctrl_reg}) else $error("control readback differs");
endmodule // serial_flash_pin_properties

bind serial_flash_pin_interface serial_flash_pin_properties chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .device_select_n(device_select_n),
  .hw_restart_n(hw_restart_n), .data_lane_in(data_lane_in), .data_lane_oe_n(data_lane_oe_n),
  .standby(standby));

// >>> verif/spi_host_model.sv
// Serial host controller model that clocks frames into the flash pins
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic so,
  output logic      sel_n,
  output logic      sck,
  output logic      si,
  output logic      pause_n
);
  int   hp = 200;
  int   hold_bit = -1;
  logic cpol = 1'b0;
  // Idle: deselected, clock still, pause released
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    pause_n = 1'b1;
  end
  // One frame of nb bits, most significant first; read bits taken late in the high phase
  task automatic xfer(input logic [7:0] mo, input int nb, output logic [7:0] mi);
    mi = 8'h00;
    sck = cpol;
    #37;
    sel_n = 1'b0;
    #(2 * hp);
    for (int i = 7; i > 7 - nb; i--) begin
      sck = 1'b0;
      if (i == hold_bit) begin
        #(2 * hp);
        pause_n = 1'b0;
        #(2 * hp);
        repeat (2) begin
          #hp sck = 1'b1;
          #hp sck = 1'b0;
        end
        #(2 * hp);
        pause_n = 1'b1;
        #(2 * hp);
      end
      si = mo[i];
      #hp sck = 1'b1;
      #hp mi[i] = so;
    end
    sck = cpol;
    #(2 * hp);
    si = ~si;
    sel_n = 1'b1;
    #(2 * hp);
  endtask
endmodule // spi_host_model

// >>> verif/serial_flash_pin_interface_tb.sv
// Self-checking bench for the serial flash pin front end
`timescale 1ns/1ns
module serial_flash_pin_interface_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        guard_n;
  logic        restart_n;
  logic [3:0]  lane_out;
  logic [3:0]  oe_n;
  logic        standby;
  logic [31:0] q;
  logic        err;
  logic [7:0]  mi;
  int          fails;
  int          n_tests;
  wire  [3:0]  lane_in;
  wire         sel_n;
  wire         sck;
  wire         si;
  wire         pause_n;

  // Device drives enabled lanes, host the rest; a released lane 1 shows the inverse of its output bit
  assign lane_in = (~oe_n & lane_out) | (oe_n & {pause_n, guard_n, ~lane_out[1], si});

  serial_flash_pin_interface dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .device_select_n(sel_n),
    .serial_clock(sck), .hw_restart_n(restart_n), .data_lane_in(lane_in), .data_lane_out(lane_out),
    .data_lane_oe_n(oe_n), .standby(standby));

  spi_host_model host (.so(lane_in[1]), .sel_n(sel_n), .sck(sck), .si(si), .pause_n(pause_n));

  // System clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic print_verdict;
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus transfer: setup, then access until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 16) begin
        fails++;
        print_verdict;
      end
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    cmp(nm, e, q);
  endtask

  task automatic t_reset;
    cmp("standby", 32'h1, {31'h0, standby});
    cmp("oe_n", 32'hf, {28'h0, oe_n});
    rdc(flash_pin_pkg::STATE_OFFSET, 32'h2, "state");
    rdc(flash_pin_pkg::CTRL_OFFSET, 32'h0, "ctrl");
    rdc(flash_pin_pkg::TX_DATA_OFFSET, 32'hff, "tx");
    rdc(8'h14, 32'h0, "unmapped");
    cmp("slverr", 32'h1, {31'h0, err});
  endtask

  task automatic t_single;
    apb(1'b1, flash_pin_pkg::TX_DATA_OFFSET, 32'h3c);
    for (int m = 0; m < 2; m++) begin
      host.cpol = m[0];
      host.xfer(8'ha5 ^ m[7:0], 8, mi);
      cmp("host rx", 32'h3c, {24'h0, mi});
      rdc(flash_pin_pkg::RX_DATA_OFFSET, {24'h0, 8'ha5 ^ m[7:0]}, "rx");
    end
    host.cpol = 1'b0;
  endtask

  task automatic t_abandon_pause;
    host.xfer(8'hff, 4, mi);
    host.xfer(8'h5a, 8, mi);
    rdc(flash_pin_pkg::RX_DATA_OFFSET, 32'h5a, "rx abandon");
    host.hold_bit = 3;
    host.xfer(8'hc3, 8, mi);
    host.hold_bit = -1;
    cmp("host rx paused", 32'h3c, {24'h0, mi});
    rdc(flash_pin_pkg::RX_DATA_OFFSET, 32'hc3, "rx paused");
  endtask

  // Rows: control bits, restart pin, fourth pin, expected restart state
  task automatic t_restart;
    logic [4:0] row [5];
    row = '{5'b00011, 5'b01010, 5'b10100, 5'b11101, 5'b01100};
    foreach (row[i]) begin
      apb(1'b1, flash_pin_pkg::CTRL_OFFSET, {30'h0, row[i][4:3]});
      restart_n <= row[i][2];
      host.pause_n <= row[i][1];
      repeat (6) @(posedge pclk);
      apb(1'b0, flash_pin_pkg::STATE_OFFSET, 32'h0);
      cmp("restart state", {31'h0, row[i][0]}, {31'h0, q[3]});
    end
    apb(1'b1, flash_pin_pkg::CTRL_OFFSET, 32'h0);
    restart_n <= 1'b1;
    host.pause_n <= 1'b1;
  endtask

  // Dual and quad lanes with the device driving; the lanes loop back into the receiver
  task automatic t_multi;
    apb(1'b1, flash_pin_pkg::CTRL_OFFSET, 32'h14);
    host.xfer(8'h00, 4, mi);
    cmp("host rx dual", 32'h60, {24'h0, mi});
    rdc(flash_pin_pkg::RX_DATA_OFFSET, 32'h3c, "rx dual");
    apb(1'b1, flash_pin_pkg::STATUS_OFFSET, 32'h40);
    apb(1'b1, flash_pin_pkg::TX_DATA_OFFSET, 32'ha5);
    apb(1'b1, flash_pin_pkg::CTRL_OFFSET, 32'h18);
    host.xfer(8'h00, 2, mi);
    cmp("host rx quad", 32'h80, {24'h0, mi});
    rdc(flash_pin_pkg::RX_DATA_OFFSET, 32'ha5, "rx quad");
    apb(1'b1, flash_pin_pkg::STATUS_OFFSET, 32'h00);
    apb(1'b1, flash_pin_pkg::CTRL_OFFSET, 32'h00);
  endtask

  task automatic t_status;
    guard_n <= 1'b0;
    apb(1'b1, flash_pin_pkg::STATUS_OFFSET, 32'h80);
    rdc(flash_pin_pkg::STATUS_OFFSET, 32'h80, "status open");
    apb(1'b1, flash_pin_pkg::STATUS_OFFSET, 32'h3c);
    rdc(flash_pin_pkg::STATUS_OFFSET, 32'h80, "status guarded");
    apb(1'b1, flash_pin_pkg::STATE_OFFSET, 32'h20);
    rdc(flash_pin_pkg::STATE_OFFSET, 32'h52, "state guarded");
    guard_n <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, flash_pin_pkg::STATUS_OFFSET, 32'hc0);
    rdc(flash_pin_pkg::STATUS_OFFSET, 32'hc0, "status guard high");
    guard_n <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, flash_pin_pkg::STATUS_OFFSET, 32'h00);
    rdc(flash_pin_pkg::STATUS_OFFSET, 32'h00, "status four lane");
  endtask

  // Reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    guard_n = 1'b1;
    restart_n = 1'b1;
    fails = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_single;
    t_abandon_pause;
    t_restart;
    t_multi;
    t_status;
    print_verdict;
  end
endmodule // serial_flash_pin_interface_tb
